// ===== logic/tops_regs.svh
`ifndef TOPS_REGS_SVH
`define TOPS_REGS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define TOPS_SLOTS       64
`define TOPS_SLOT_W      6
`define TOPS_OUTS        32
`define TOPS_BASE_W      5
`define TOPS_MASK_W      16
`define TOPS_DUR_W       16

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TOPS_OFF_SLOT    8'h00
`define TOPS_OFF_BASE    8'h04
`define TOPS_OFF_MASK    8'h08
`define TOPS_OFF_DUR     8'h0c
`define TOPS_OFF_CTRL    8'h10
`define TOPS_OFF_ACT_LO  8'h14
`define TOPS_OFF_ACT_HI  8'h18
`define TOPS_OFF_OUTS    8'h1c
`define TOPS_OFF_LEVEL   8'h20

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define TOPS_CTRL_START_BIT 0
`define TOPS_CTRL_INV_BIT   1
`define TOPS_RST_LEVEL   32'h0000_0000
`define TOPS_RST_MASK    16'h0001
`define TOPS_RST_DUR     16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TOPS_MS_NS       1000000
`define TOPS_CLK_NS      25

`endif

// ===== logic/tops_pkg.sv
`default_nettype none
`include "tops_regs.svh"
package tops_pkg;

  // staged command for the next slot start
  typedef struct packed {
    logic [`TOPS_SLOT_W-1:0] slot;
    logic [`TOPS_BASE_W-1:0] base;
    logic [`TOPS_MASK_W-1:0] mask;
    logic [`TOPS_DUR_W-1:0]  dur;
    logic                    inv;
  } tops_cmd_type;

  // outputs forced on and forced off
  typedef struct packed {
    logic [`TOPS_OUTS-1:0] on;
    logic [`TOPS_OUTS-1:0] off;
  } tops_drive_type;

endpackage
`default_nettype wire

// ===== logic/tops_ms_tick.sv
`timescale 1ns/10ps
`default_nettype none
module tops_ms_tick #(
  parameter int unsigned CYCLES = 40000
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  output logic      tick
);

  logic [31:0] cnt_ff;
  logic        tick_ff;
  wire  logic  wrap_w = (cnt_ff == 32'(CYCLES - 1));

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff  <= 32'h0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= wrap_w ? 32'h0 : cnt_ff + 32'h1;
      tick_ff <= wrap_w;
    end
  end

  assign tick = tick_ff;

endmodule // tops_ms_tick
`default_nettype wire

// ===== logic/tops_slots.sv
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "tops_regs.svh"
module tops_slots #(
  parameter int unsigned MS_CYCLES = `TOPS_MS_NS / `TOPS_CLK_NS
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic      [`TOPS_OUTS-1:0] out_pins
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [`TOPS_OUTS-1:0] tops_spread(
    input logic [`TOPS_BASE_W-1:0] base,
    input logic [`TOPS_MASK_W-1:0] mask
  );
    logic [`TOPS_OUTS+`TOPS_MASK_W-1:0] wide;
    // mask bits past output 31 fall off the top
    wide = {{`TOPS_OUTS{1'b0}}, mask} << base;
    return wide[`TOPS_OUTS-1:0];
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tops_pkg::tops_cmd_type    cmd_ff;
  tops_pkg::tops_drive_type  run_w;
  tops_pkg::tops_drive_type  end_w;
  logic [31:0]               prdata_ff;
  logic                      pready_ff;
  logic                      pslverr_ff;
  logic [`TOPS_OUTS-1:0]     level_ff;
  logic [`TOPS_OUTS-1:0]     out_ff;
  logic [`TOPS_OUTS-1:0]     nxt_level;
  logic [`TOPS_OUTS-1:0]     nxt_out;
  logic [`TOPS_BASE_W-1:0]   base_ff [`TOPS_SLOTS];
  logic [`TOPS_MASK_W-1:0]   mask_ff [`TOPS_SLOTS];
  logic [`TOPS_DUR_W-1:0]    cnt_ff  [`TOPS_SLOTS];
  logic                      act_ff  [`TOPS_SLOTS];
  logic                      inv_ff  [`TOPS_SLOTS];
  logic [`TOPS_OUTS-1:0]     sel_w   [`TOPS_SLOTS];
  logic                      exp_w   [`TOPS_SLOTS];
  logic                      go_w    [`TOPS_SLOTS];
  logic [`TOPS_SLOTS-1:0]    act_vec_w;
  logic [31:0]               rd_w;
  logic                      err_w;
  logic                      ms_tick;

  // ----------------------------------------------------------------
  // millisecond prescaler
  // ----------------------------------------------------------------
  tops_ms_tick #(
    .CYCLES (MS_CYCLES)
  ) u_tick (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .tick    (ms_tick)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // one wait state: pready rises in the second access cycle
  wire logic acc_w     = psel & penable & ~pready_ff;
  wire logic wr_w      = psel & penable & pready_ff & pwrite;
  wire logic wr_slot_w = wr_w & (paddr == `TOPS_OFF_SLOT);
  wire logic wr_base_w = wr_w & (paddr == `TOPS_OFF_BASE);
  wire logic wr_mask_w = wr_w & (paddr == `TOPS_OFF_MASK);
  wire logic wr_dur_w  = wr_w & (paddr == `TOPS_OFF_DUR);
  wire logic wr_ctrl_w = wr_w & (paddr == `TOPS_OFF_CTRL);
  wire logic wr_lvl_w  = wr_w & (paddr == `TOPS_OFF_LEVEL);
  wire logic start_w   = wr_ctrl_w & pwdata[`TOPS_CTRL_START_BIT];
  wire logic start_inv = pwdata[`TOPS_CTRL_INV_BIT];

  always_comb begin
    rd_w  = 32'h0;
    err_w = 1'b0;
    if (paddr == `TOPS_OFF_SLOT) begin
      rd_w = {26'h0, cmd_ff.slot};
    end else if (paddr == `TOPS_OFF_BASE) begin
      rd_w = {27'h0, cmd_ff.base};
    end else if (paddr == `TOPS_OFF_MASK) begin
      rd_w = {16'h0, cmd_ff.mask};
    end else if (paddr == `TOPS_OFF_DUR) begin
      rd_w = {16'h0, cmd_ff.dur};
    end else if (paddr == `TOPS_OFF_CTRL) begin
      rd_w = {30'h0, cmd_ff.inv, 1'b0};
    end else if (paddr == `TOPS_OFF_ACT_LO) begin
      rd_w = act_vec_w[31:0];
    end else if (paddr == `TOPS_OFF_ACT_HI) begin
      rd_w = act_vec_w[63:32];
    end else if (paddr == `TOPS_OFF_OUTS) begin
      rd_w = out_ff;
    end else if (paddr == `TOPS_OFF_LEVEL) begin
      rd_w = level_ff;
    end else begin
      err_w = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else begin
      pready_ff  <= acc_w;
      pslverr_ff <= acc_w & err_w;
      prdata_ff  <= (acc_w & ~pwrite) ? rd_w : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // staged command
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_ff <= '{slot: '0, base: '0, mask: `TOPS_RST_MASK, dur: `TOPS_RST_DUR, inv: 1'b0};
    end else begin
      if (wr_slot_w) cmd_ff.slot <= pwdata[`TOPS_SLOT_W-1:0];
      if (wr_base_w) cmd_ff.base <= pwdata[`TOPS_BASE_W-1:0];
      if (wr_mask_w) cmd_ff.mask <= pwdata[`TOPS_MASK_W-1:0];
      if (wr_dur_w)  cmd_ff.dur  <= pwdata[`TOPS_DUR_W-1:0];
      if (wr_ctrl_w) cmd_ff.inv  <= start_inv;
    end
  end

  // ----------------------------------------------------------------
  // timer slots
  // ----------------------------------------------------------------
  for (genvar s = 0; s < `TOPS_SLOTS; s++) begin : g_slot
    assign go_w[s]  = start_w & (cmd_ff.slot == `TOPS_SLOT_W'(s));
    assign sel_w[s] = tops_spread(base_ff[s], mask_ff[s]);
    // zero duration ends at the next tick
    assign exp_w[s] = act_ff[s] & ms_tick & (cnt_ff[s] <= `TOPS_DUR_W'(1));

    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        act_ff[s]  <= 1'b0;
        cnt_ff[s]  <= '0;
        inv_ff[s]  <= 1'b0;
        base_ff[s] <= '0;
        mask_ff[s] <= `TOPS_RST_MASK;
      end else if (go_w[s]) begin
        // restarting a busy slot simply reloads it
        act_ff[s]  <= 1'b1;
        cnt_ff[s]  <= cmd_ff.dur;
        inv_ff[s]  <= start_inv;
        base_ff[s] <= cmd_ff.base;
        mask_ff[s] <= cmd_ff.mask;
      end else if (exp_w[s]) begin
        act_ff[s] <= 1'b0;
        cnt_ff[s] <= '0;
      end else if (act_ff[s] && ms_tick) begin
        cnt_ff[s] <= cnt_ff[s] - `TOPS_DUR_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // output merge
  // ----------------------------------------------------------------
  // on wins over off when two running or two expiring slots fight over a pin; a running slot beats an expiring one
  always_comb begin
    run_w     = '0;
    end_w     = '0;
    act_vec_w = '0;
    for (int i = 0; i < `TOPS_SLOTS; i++) begin
      act_vec_w[i] = act_ff[i];
      if (act_ff[i] && !exp_w[i]) begin
        if (inv_ff[i]) run_w.off = run_w.off | sel_w[i];
        else           run_w.on  = run_w.on  | sel_w[i];
      end
      if (exp_w[i]) begin
        if (inv_ff[i]) end_w.on  = end_w.on  | sel_w[i];
        else           end_w.off = end_w.off | sel_w[i];
      end
    end
  end

  // unselected bits keep the software level
  assign nxt_level = ((wr_lvl_w ? pwdata : level_ff) & ~end_w.off) | end_w.on;
  assign nxt_out   = (nxt_level & ~run_w.off) | run_w.on;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      level_ff <= `TOPS_RST_LEVEL;
      out_ff   <= `TOPS_RST_LEVEL;
    end else begin
      level_ff <= nxt_level;
      out_ff   <= nxt_out;
    end
  end

  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign out_pins = out_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_access;
    psel && penable && !pready_ff;
  endsequence

  sequence s_done;
    pready_ff ##1 !pready_ff;
  endsequence

  a_apb_handshake: assert property (s_access |=> s_done)
    else $error("apb ready did not pulse for one cycle");

  a_slot_start: assert property (
    start_w |=> act_ff[$past(cmd_ff.slot)])
    else $error("started slot not active");

  a_base_load: assert property (
    start_w |=> base_ff[$past(cmd_ff.slot)] == $past(cmd_ff.base))
    else $error("slot base not loaded");

  a_mask_load: assert property (
    start_w |=> mask_ff[$past(cmd_ff.slot)] == $past(cmd_ff.mask))
    else $error("slot mask not loaded");

  a_mask_map: assert property (
    act_ff[1] && mask_ff[1] == 16'h000d && base_ff[1] == 5'h0a
      |-> sel_w[1] == 32'h0000_3400)
    else $error("mask bits not mapped from base");

  a_others_kept: assert property (
    act_ff[0] && run_w.on == sel_w[0] && run_w.off == '0
      |=> ((out_ff ^ $past(nxt_level)) & ~$past(sel_w[0])) == '0)
    else $error("unselected output disturbed");

  a_run_on: assert property (
    act_ff[0] && !inv_ff[0] && !exp_w[0]
      |=> (out_ff & $past(sel_w[0])) == $past(sel_w[0]))
    else $error("running slot did not drive outputs on");

  a_plain_end: assert property (
    exp_w[0] && !inv_ff[0]
      |=> (level_ff & $past(sel_w[0]) & ~$past(end_w.on)) == '0)
    else $error("expired slot did not clear outputs");

  a_invert_end: assert property (
    exp_w[0] && inv_ff[0] |=> (level_ff & $past(sel_w[0])) == $past(sel_w[0]))
    else $error("inverted slot did not restore outputs on");

  a_count_down: assert property (
    ms_tick && act_ff[0] && cnt_ff[0] > 16'h0001 && !go_w[0]
      |=> cnt_ff[0] == $past(cnt_ff[0]) - 16'h0001)
    else $error("slot count did not drop on tick");

  a_tick_single: assert property (
    ms_tick |=> !ms_tick)
    else $error("millisecond tick longer than one cycle");

  a_err_ready: assert property (
    pslverr_ff |-> pready_ff)
    else $error("slave error outside ready");

  a_rdata_idle: assert property (
    !pready_ff |-> prdata_ff == 32'h0)
    else $error("read data not zero outside ready");

  a_slot_idle: assert property (
    exp_w[0] && !go_w[0] |=> !act_ff[0])
    else $error("expired slot still active");

  a_load_dur: assert property (
    go_w[0] |=> cnt_ff[0] == $past(cmd_ff.dur))
    else $error("slot count not loaded from duration");

  a_count_hold: assert property (
    act_ff[0] && !ms_tick && !go_w[0] |=> $stable(cnt_ff[0]))
    else $error("slot count moved without a tick");

  a_level_write: assert property (
    wr_lvl_w && end_w.on == '0 && end_w.off == '0 |=> level_ff == $past(pwdata))
    else $error("software level not taken");

  a_invert_run: assert property (
    act_ff[1] && inv_ff[1] && !exp_w[1] && (run_w.on & sel_w[1]) == '0
      |=> (out_ff & $past(sel_w[1])) == '0)
    else $error("inverted slot did not drive outputs off");

endmodule // tops_slots
`default_nettype wire

// ===== dv/tb_timed_output_pulse_slots.sv
`timescale 1ns/10ps
`default_nettype none
`include "tops_regs.svh"
module tb_timed_output_pulse_slots;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int unsigned MS = 4;  // short tick keeps the run small
  logic                  ref_clk;
  logic                  reset_n;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic [`TOPS_OUTS-1:0] out_pins;
  logic [31:0]           rd;
  logic                  er;
  int                    mismatches;
  int                    checks;

  tops_slots #(.MS_CYCLES(MS)) dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .out_pins(out_pins));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // request held until pready is seen at a rising edge; only the watchdog ends a wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    chk(32'(n), 32'h2, "one wait state");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // bits beyond output 31 fall off the top
  function automatic logic [31:0] field(input logic [4:0] b, input logic [15:0] m);
    logic [47:0] w;
    w = {32'h0, m} << b;
    return w[31:0];
  endfunction

  // loads and starts a slot without waiting for its period
  task automatic start_slot(input logic [5:0] s, input logic [4:0] b, input logic [15:0] m,
                            input logic [15:0] d, input logic inv);
    apb(1'b1, `TOPS_OFF_SLOT, {26'h0, s});
    apb(1'b1, `TOPS_OFF_BASE, {27'h0, b});
    apb(1'b1, `TOPS_OFF_MASK, {16'h0, m});
    apb(1'b1, `TOPS_OFF_DUR, {16'h0, d});
    apb(1'b1, `TOPS_OFF_CTRL, {30'h0, inv, 1'b1});
  endtask

  task automatic run_one(input logic [5:0] s, input logic [4:0] b, input logic [15:0] m,
                         input logic [15:0] d, input logic inv, input logic [31:0] keep);
    logic [31:0] f, st, en;
    time         t0;
    int          n, el, nn;
    f  = field(b, m);
    st = inv ? (keep & ~f) : (keep | f);
    en = inv ? (keep | f) : (keep & ~f);
    nn = (d == 16'h0) ? 1 : int'(d);
    start_slot(s, b, m, d, inv);
    t0 = $time;
    // pins still show the old level at the first edge after the start commits
    repeat (2) @(posedge ref_clk);
    if (d >= 16'h2) begin
      @(posedge ref_clk);
      chk(out_pins, st, "start level");
    end
    n = 0;
    while (out_pins !== en && n < 40 * MS) begin
      @(posedge ref_clk);
      n++;
    end
    el = int'(($time - t0) / 25);
    checks++;
    if (el < (nn - 1) * MS + 1 || el > nn * MS + 3) begin
      mismatches++;
      $display("CHECK FAILED t=%0t period %0d cycles for %0d ms", $time, el, nn);
    end
    chk(out_pins, en, "end level");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial begin
    #(60000 * 25);
    mismatches++;
    close_out();
  end

  initial begin
    logic [7:0]  ad [8];
    logic [31:0] ex [8];
    int          n;
    ad = '{`TOPS_OFF_SLOT, `TOPS_OFF_BASE, `TOPS_OFF_MASK, `TOPS_OFF_DUR,
           `TOPS_OFF_CTRL, `TOPS_OFF_ACT_LO, `TOPS_OFF_OUTS, `TOPS_OFF_LEVEL};
    ex = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    reset_n    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    mismatches = 0;
    checks     = 0;
    rd = $urandom(39);
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ad[i], 32'h0);
      chk(rd, ex[i], "reset value");
    end
    apb(1'b0, `TOPS_OFF_ACT_HI, 32'h0);
    chk(rd, 32'h0, "reset act hi");
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped err");
    apb(1'b1, `TOPS_OFF_OUTS, 32'hffff_ffff);
    apb(1'b0, `TOPS_OFF_OUTS, 32'h0);
    chk(rd, 32'h0, "ro ignored");
    $display("test reset done");
    // slot 42 keeps output 0 on while slot 1 runs the inverted group
    apb(1'b1, `TOPS_OFF_LEVEL, 32'h0000_0800);
    start_slot(6'd42, 5'd0, 16'h0001, 16'd12, 1'b0);
    run_one(6'd1, 5'd10, 16'd13, 16'd3, 1'b1, 32'h0000_0801);
    apb(1'b0, `TOPS_OFF_ACT_HI, 32'h0);
    chk(rd, 32'h0000_0400, "slot 42 active");
    apb(1'b0, `TOPS_OFF_ACT_LO, 32'h0);
    chk(rd, 32'h0, "slot 1 done");
    apb(1'b0, `TOPS_OFF_CTRL, 32'h0);
    chk(rd, 32'h2, "invert readback");
    n = 0;
    while (out_pins[0] !== 1'b0 && n < 80) begin
      @(posedge ref_clk);
      n++;
    end
    chk(out_pins, 32'h0000_3c00, "both expired");
    apb(1'b0, `TOPS_OFF_LEVEL, 32'h0);
    chk(rd, 32'h0000_3c00, "end level kept");
    $display("test concurrent done");
    apb(1'b1, `TOPS_OFF_LEVEL, 32'h0);
    run_one(6'd63, 5'd31, 16'h0003, 16'd0, 1'b0, 32'h0);
    run_one(6'd0, 5'd0, 16'hffff, 16'd2, 1'b0, 32'h0);
    $display("test corners done");
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, `TOPS_OFF_LEVEL, 32'h0);
      run_one(6'($urandom), 5'($urandom), 16'($urandom) | 16'h1,
              16'(2 + $urandom % 5), 1'($urandom), 32'h0);
    end
    $display("test random done");
    close_out();
  end
endmodule // tb_timed_output_pulse_slots
`default_nettype wire
